// file: include/crypto_run_params.svh
// Register map, field positions and reset values of the crypto run control block
`ifndef CRYPTO_RUN_PARAMS_SVH
`define CRYPTO_RUN_PARAMS_SVH
`define CR_ADDR_CONFIG 32'h40020000
`define CR_ADDR_START 32'h40020004
`define CR_ADDR_SRC 32'h40020008
`define CR_ADDR_LEN 32'h4002000c
`define CR_ADDR_DST 32'h40020010
`define CR_ADDR_STATUS 32'h40020014
`define CR_ADDR_CLRIRQ 32'h40020018
`define CR_ADDR_MVW0 32'h4002001c
`define CR_ADDR_IRQ_STAT 32'h40020030
`define CR_ADDR_IRQ_MASK 32'h40020034
`define CR_CFG_MORE_IN 16
`define CR_CFG_IRQ_EN 8
`define CR_CFG_MODE_LSB 2
`define CR_START_BIT 0
`define CR_CLRIRQ_BIT 0
`define CR_ST_INACTIVE 0
`define CR_ST_WAIT_IN 1
`define CR_ST_IRQ 2
`define CR_LEN_MSB 23
`define CR_STATUS_RST 32'h00000001
`define CR_IRQ_MASK_RST 2'h3
`define CR_MODE_CTR 2'h2
`define CR_MODE_CBC 2'h3
`define CR_WORD_BYTES 4
`endif

// file: include/crypto_run_pkg.sv
// Types shared by the crypto run control modules
`default_nettype none
package crypto_run_pkg;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_FETCH = 7'h02,
    ST_FWAIT = 7'h04,
    ST_SEND = 7'h08,
    ST_OWAIT = 7'h10,
    ST_WRITE = 7'h20,
    ST_WAITIN = 7'h40
  } run_state_t;
  typedef enum logic [1:0] {
    RESP_OKAY = 2'h0,
    RESP_SLVERR = 2'h2
  } axi_resp_t;
endpackage
`default_nettype wire

// file: include/blk_if.sv
// Carrier between the run controller and the input block assembler
`timescale 1ns/100ps
`default_nettype none
interface blk_if #(parameter int W = 4);
  logic push;
  logic clear;
  logic [31:0] word;
  logic [2:0] nbytes;
  logic [W*32-1:0] block;
  logic [$clog2(W):0] count;
  modport asm (input push, clear, word, nbytes, output block, count);
  modport ctl (output push, clear, word, nbytes, input block, count);
endinterface
`default_nettype wire

// file: logic/block_assembler.sv
// Gathers fetched words into one cipher block, zero padding a short tail
`timescale 1ns/100ps
`default_nettype none
`include "crypto_run_params.svh"
module block_assembler
  import crypto_run_pkg::*;
#(
  parameter int W = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  blk_if.asm bus
);
  localparam int CW = $clog2(W) + 1;
  typedef struct packed {
    logic [W*32-1:0] block;
    logic [CW-1:0] count;
  } asm_t;
  asm_t q;
  asm_t d;
  logic [31:0] masked;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    for (int b = 0; b < `CR_WORD_BYTES; b++) begin
      masked[b*8+:8] = (b < int'(bus.nbytes)) ? bus.word[b*8+:8] : 8'h00;
    end
    if (bus.clear) begin
      d.block = '0;
      d.count = '0;
    end else if (bus.push && q.count < CW'(W)) begin
      for (int i = 0; i < W; i++) begin
        if (q.count == CW'(i)) begin
          d.block[i*32+:32] = masked;
        end
      end
      d.count = q.count + CW'(1);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bus.block = q.block;
  assign bus.count = q.count;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_pad_tail_zero: assert property (
    bus.push && !bus.clear && bus.nbytes < 3'h4 && q.count < CW'(W)
    |=> (q.block >> (32 * int'($past(q.count)) + 8 * int'($past(bus.nbytes)))) == '0)
    else $error("short word not zero padded");
endmodule
`default_nettype wire

// file: logic/crypto_run_ctrl.sv
// Run control, pointer tracking, status and interrupt of the crypto DMA engine
// Behaviour
// - Writing one to start bit 0 launches processing; bit reads zero.
// - Source pointer holds where input bytes are fetched from.
// - Length holds 24-bit input byte count; upper eight bits reserved.
// - A final partial block is padded with zero bytes.
// - Result pointer holds where output data is written.
// - Source, length and result pointer advance as processing runs.
// - Status bit 2 mirrors the interrupt request line.
// - With more-input set, status bit 1 rises when fragment is consumed.
// - While waiting for input, inactive flag stays zero.
// - Start while waiting continues with new fragment, clears wait flag.
// - Status bit 0 is zero while busy, one when idle; resets to one.
// - Writing one to interrupt-clear bit 0 drops the request; reads zero.
// - CBC uses mode word as IV low word; CTR as counter low word.
// - In CTR the mode word seeds the 32-bit per-block counter.
// - Other cipher modes ignore the mode word.
// - Without more-input finish and go inactive; with it stop and wait.
// - Interrupt enable raises a request at end of operation, else none.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "crypto_run_params.svh"
module crypto_run_ctrl
  import crypto_run_pkg::*;
#(
  parameter int BLOCK_WORDS = 4
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic MEM_REQ,
  output logic MEM_WE,
  output logic [31:0] MEM_ADDR,
  output logic [31:0] MEM_WDATA,
  input wire logic MEM_GNT,
  input wire logic MEM_RVALID,
  input wire logic [31:0] MEM_RDATA,
  output logic CORE_IN_VALID,
  output logic [BLOCK_WORDS*32-1:0] CORE_IN_DATA,
  output logic CORE_FIRST,
  output logic [1:0] CORE_MODE,
  output logic [31:0] CORE_VECTOR_LOW,
  input wire logic CORE_IN_READY,
  input wire logic CORE_OUT_VALID,
  input wire logic [BLOCK_WORDS*32-1:0] CORE_OUT_DATA,
  output logic CORE_OUT_READY,
  output logic IRQ
);
  localparam int WI = $clog2(BLOCK_WORDS);
  localparam int CW = WI + 1;
  localparam logic [WI-1:0] LAST = WI'(BLOCK_WORDS - 1);

  typedef struct packed {
    run_state_t st;
    logic [31:0] src;
    logic [23:0] len;
    logic [31:0] dst;
    logic [31:0] mvw0;
    logic more_in;
    logic irq_en;
    logic [1:0] mode;
    logic [1:0] stat;
    logic [1:0] mask;
    logic [31:0] ctr;
    logic first;
    logic [BLOCK_WORDS*32-1:0] obuf;
    logic [WI-1:0] widx;
    logic aw_h;
    logic [31:0] aw_a;
    logic w_h;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic bv;
    logic [1:0] bresp;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rresp;
  } regs_t;

  localparam regs_t RST_VAL = '{st: ST_IDLE, mask: `CR_IRQ_MASK_RST, default: '0};

  regs_t q;
  regs_t d;
  blk_if #(.W(BLOCK_WORDS)) blk();

  logic aw_fire;
  logic w_fire;
  logic wr_go;
  logic [31:0] wa;
  logic [31:0] wdat;
  logic [3:0] wstb;
  logic start_wr;
  logic clr_wr;
  logic sw_own;
  logic irq;
  logic done_ev;
  logic wait_ev;
  logic [1:0] clr_bits;
  logic [31:0] len_w;
  logic [2:0] nbytes;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] v,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8+:8] = v[b*8+:8];
      end
    end
    return r;
  endfunction

  function automatic logic is_mapped(input logic [31:0] a);
    case (a)
      `CR_ADDR_CONFIG, `CR_ADDR_START, `CR_ADDR_SRC, `CR_ADDR_LEN, `CR_ADDR_DST,
      `CR_ADDR_STATUS, `CR_ADDR_CLRIRQ, `CR_ADDR_MVW0, `CR_ADDR_IRQ_STAT,
      `CR_ADDR_IRQ_MASK: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] rd_mux(input logic [31:0] a);
    logic [31:0] r;
    r = 32'h0; // Write-only and reserved bits read zero
    case (a)
      `CR_ADDR_CONFIG: begin
        r[`CR_CFG_MORE_IN] = q.more_in;
        r[`CR_CFG_IRQ_EN] = q.irq_en;
        r[`CR_CFG_MODE_LSB+:2] = q.mode;
      end
      `CR_ADDR_SRC: r = q.src;
      `CR_ADDR_LEN: r[`CR_LEN_MSB:0] = q.len;
      `CR_ADDR_DST: r = q.dst;
      `CR_ADDR_STATUS: begin
        r[`CR_ST_IRQ] = irq;
        r[`CR_ST_WAIT_IN] = (q.st == ST_WAITIN);
        r[`CR_ST_INACTIVE] = (q.st == ST_IDLE);
      end
      `CR_ADDR_MVW0: r = q.mvw0;
      `CR_ADDR_IRQ_STAT: r[1:0] = q.stat;
      `CR_ADDR_IRQ_MASK: r[1:0] = q.mask;
      default: r = 32'h0;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  assign S_AXI_AWREADY = !q.aw_h && !q.bv;
  assign S_AXI_WREADY = !q.w_h && !q.bv;
  assign S_AXI_ARREADY = !q.rv;
  assign aw_fire = S_AXI_AWVALID && S_AXI_AWREADY;
  assign w_fire = S_AXI_WVALID && S_AXI_WREADY;
  assign wr_go = (q.aw_h || aw_fire) && (q.w_h || w_fire);
  assign wa = q.aw_h ? q.aw_a : S_AXI_AWADDR;
  assign wdat = q.w_h ? q.w_d : S_AXI_WDATA;
  assign wstb = q.w_h ? q.w_s : S_AXI_WSTRB;
  assign start_wr = wr_go && wa == `CR_ADDR_START && wstb[0] && wdat[`CR_START_BIT];
  assign clr_wr = wr_go && wa == `CR_ADDR_CLRIRQ && wstb[0] && wdat[`CR_CLRIRQ_BIT];
  // Pointers belong to the engine while it runs, so software only edits them at rest
  assign sw_own = (q.st == ST_IDLE) || (q.st == ST_WAITIN);
  assign len_w = wmerge({8'h00, q.len}, wdat, wstb);
  assign nbytes = (q.len >= 24'(`CR_WORD_BYTES)) ? 3'h4 : q.len[2:0];
  assign irq = |(q.stat & q.mask);
  assign clr_bits = (wr_go && wa == `CR_ADDR_IRQ_STAT && wstb[0] ? wdat[1:0] : 2'h0)
                    | (clr_wr ? 2'h3 : 2'h0);

  assign blk.word = MEM_RDATA;
  assign blk.nbytes = nbytes;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    done_ev = 1'b0;
    wait_ev = 1'b0;
    blk.push = 1'b0;
    blk.clear = 1'b0;
    if (aw_fire) begin
      d.aw_h = 1'b1;
      d.aw_a = S_AXI_AWADDR;
    end
    if (w_fire) begin
      d.w_h = 1'b1;
      d.w_d = S_AXI_WDATA;
      d.w_s = S_AXI_WSTRB;
    end
    if (wr_go) begin
      d.aw_h = 1'b0;
      d.w_h = 1'b0;
      d.bv = 1'b1;
      d.bresp = is_mapped(wa) ? RESP_OKAY : RESP_SLVERR;
      case (wa)
        `CR_ADDR_CONFIG: begin
          if (wstb[2]) d.more_in = wdat[`CR_CFG_MORE_IN];
          if (wstb[1]) d.irq_en = wdat[`CR_CFG_IRQ_EN];
          if (wstb[0]) d.mode = wdat[`CR_CFG_MODE_LSB+:2];
        end
        `CR_ADDR_SRC: if (sw_own) d.src = wmerge(q.src, wdat, wstb);
        `CR_ADDR_LEN: if (sw_own) d.len = len_w[`CR_LEN_MSB:0];
        `CR_ADDR_DST: if (sw_own) d.dst = wmerge(q.dst, wdat, wstb);
        `CR_ADDR_MVW0: d.mvw0 = wmerge(q.mvw0, wdat, wstb);
        `CR_ADDR_IRQ_MASK: if (wstb[0]) d.mask = wdat[1:0];
        default: ;
      endcase
    end
    if (q.bv && S_AXI_BREADY) d.bv = 1'b0;
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      d.rv = 1'b1;
      d.rd = rd_mux(S_AXI_ARADDR);
      d.rresp = is_mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
    end else if (q.rv && S_AXI_RREADY) begin
      d.rv = 1'b0;
    end

    case (q.st)
      ST_IDLE: begin
        if (start_wr) begin
          d.st = ST_FETCH;
          d.ctr = q.mvw0;
          d.first = 1'b1;
          blk.clear = 1'b1;
        end
      end
      ST_FETCH: begin
        if (blk.count == CW'(BLOCK_WORDS)) begin
          d.st = ST_SEND;
        end else if (q.len == 24'h0) begin
          // A partial block stays held across a fragment boundary
          if (q.more_in) begin
            d.st = ST_WAITIN;
            wait_ev = 1'b1;
          end else if (blk.count != '0) begin
            d.st = ST_SEND;
          end else begin
            d.st = ST_IDLE;
            done_ev = 1'b1;
          end
        end else if (MEM_GNT) begin
          d.st = ST_FWAIT;
        end
      end
      ST_FWAIT: begin
        if (MEM_RVALID) begin
          blk.push = 1'b1;
          d.src = q.src + 32'(`CR_WORD_BYTES);
          d.len = q.len - 24'(nbytes);
          d.st = ST_FETCH;
        end
      end
      ST_SEND: begin
        if (CORE_IN_READY) begin
          d.st = ST_OWAIT;
          d.first = 1'b0;
          if (q.mode == `CR_MODE_CTR) d.ctr = q.ctr + 32'h1;
        end
      end
      ST_OWAIT: begin
        if (CORE_OUT_VALID) begin
          d.obuf = CORE_OUT_DATA;
          d.widx = '0;
          d.st = ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (MEM_GNT) begin
          d.dst = q.dst + 32'(`CR_WORD_BYTES);
          d.widx = q.widx + WI'(1);
          if (q.widx == LAST) begin
            blk.clear = 1'b1;
            d.st = ST_FETCH;
          end
        end
      end
      ST_WAITIN: begin
        if (start_wr) d.st = ST_FETCH;
      end
      default: d.st = ST_IDLE;
    endcase

    // A new event wins over a clear in the same cycle
    d.stat = (q.stat & ~clr_bits) | ({wait_ev, done_ev} & {2{q.irq_en}});
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      q <= RST_VAL;
    end else begin
      q <= d;
    end
  end

  block_assembler #(.W(BLOCK_WORDS)) u_asm (
    .clk_sys(CLK_SYS),
    .rst(RST),
    .bus(blk)
  );

  ////////////////////////////////////////////////////////////////////////////
  assign S_AXI_BVALID = q.bv;
  assign S_AXI_BRESP = q.bresp;
  assign S_AXI_RVALID = q.rv;
  assign S_AXI_RDATA = q.rd;
  assign S_AXI_RRESP = q.rresp;
  assign MEM_REQ = (q.st == ST_FETCH && q.len != 24'h0 && blk.count != CW'(BLOCK_WORDS))
                   || q.st == ST_WRITE;
  assign MEM_WE = (q.st == ST_WRITE);
  assign MEM_ADDR = (q.st == ST_WRITE) ? q.dst : q.src;
  assign MEM_WDATA = q.obuf[q.widx*32+:32];
  assign CORE_IN_VALID = (q.st == ST_SEND);
  assign CORE_IN_DATA = blk.block;
  assign CORE_FIRST = q.first;
  assign CORE_MODE = q.mode;
  // Vector word is hidden outside the chaining and counter modes
  assign CORE_VECTOR_LOW = (q.mode == `CR_MODE_CTR) ? q.ctr :
                           (q.mode == `CR_MODE_CBC) ? q.mvw0 : 32'h0;
  assign CORE_OUT_READY = (q.st == ST_OWAIT);
  assign IRQ = irq;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  sequence s_last_write;
    q.st == ST_WRITE && MEM_GNT && q.widx == LAST;
  endsequence
  sequence s_final_check;
    q.st == ST_FETCH && q.len == 24'h0 && !q.more_in && q.irq_en;
  endsequence

  a_start_launch: assert property (
    q.st == ST_IDLE && start_wr |=> q.st == ST_FETCH && q.ctr == $past(q.mvw0))
    else $error("start did not launch");
  a_start_reads0: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == `CR_ADDR_START |=> q.rd == 32'h0)
    else $error("start register read nonzero");
  a_len_reserved: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == `CR_ADDR_LEN
    |=> q.rd[31:24] == 8'h0 && q.rd[23:0] == $past(q.len))
    else $error("length read wrong");
  a_src_advance: assert property (
    q.st == ST_FWAIT && MEM_RVALID
    |=> q.src == $past(q.src) + 32'h4 && q.len == $past(q.len) - 24'($past(nbytes)))
    else $error("source pointer not advanced");
  a_irq_mirror: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == `CR_ADDR_STATUS
    |=> q.rd[2] == $past(IRQ) && q.rd[31:3] == 29'h0)
    else $error("status irq bit not mirroring line");
  a_wait_flags: assert property (
    q.st == ST_WAITIN |-> rd_mux(`CR_ADDR_STATUS) == {29'h0, IRQ, 2'b10})
    else $error("waiting status wrong");
  a_resume_clear: assert property (
    q.st == ST_WAITIN && start_wr
    |=> q.st == ST_FETCH && (rd_mux(`CR_ADDR_STATUS) & 32'h2) == 32'h0)
    else $error("resume did not clear wait flag");
  a_clrirq_drop: assert property (
    clr_wr && !done_ev && !wait_ev |=> q.stat == 2'h0 && !IRQ)
    else $error("interrupt clear ineffective");
  a_ctr_step: assert property (
    q.st == ST_SEND && CORE_IN_READY && q.mode == `CR_MODE_CTR |=> q.ctr == $past(q.ctr) + 32'h1)
    else $error("counter not stepped");
  a_vec_ignored: assert property (
    q.mode[1] == 1'b0 |-> CORE_VECTOR_LOW == 32'h0)
    else $error("vector word leaked");
  a_final_done: assert property (
    s_last_write ##1 s_final_check |=> q.st == ST_IDLE && q.stat[0])
    else $error("final block did not finish");
  a_irq_gate: assert property (
    !q.irq_en && !q.stat[0] && clr_bits == 2'h0 |=> !q.stat[0])
    else $error("interrupt raised while disabled");
endmodule
`default_nettype wire

// file: bench/crypto_partner_models.sv
// Memory and cipher core models facing the run controller
`timescale 1ns/100ps
`default_nettype none
module mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic req,
  input wire logic we,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  output logic gnt,
  output logic rvalid,
  output logic [31:0] rdata
);
  logic [31:0] mem [0:63];
  logic [31:0] last_q;
  logic tick_q;
  // Slow mode grants every other cycle; idle data is inverted so stale reads show
  assign gnt = req && (!slow || tick_q);
  assign rdata = rvalid ? last_q : ~last_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_q <= 1'b0;
      rvalid <= 1'b0;
      last_q <= 32'h0;
    end else begin
      tick_q <= !tick_q;
      rvalid <= gnt && !we;
      if (gnt && !we) last_q <= mem[addr[7:2]];
      if (gnt && we) mem[addr[7:2]] <= wdata;
    end
  end
endmodule
////////////////////////////////////////
module core_model #(parameter int W = 4) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [W*32-1:0] in_data,
  input wire logic out_ready,
  output logic in_ready,
  output logic out_valid,
  output logic [W*32-1:0] out_data
);
  logic full_q;
  logic [W*32-1:0] blk_q;
  // Result is the inverse of the block, so zero padding lands as all ones
  assign in_ready = !full_q;
  assign out_valid = full_q;
  assign out_data = full_q ? ~blk_q : blk_q;
  always @(posedge clk or posedge rst) begin
    if (rst) full_q <= 1'b0;
    else if (in_valid && in_ready) begin
      full_q <= 1'b1;
      blk_q <= in_data;
    end else if (out_valid && out_ready) full_q <= 1'b0;
  end
endmodule
`default_nettype wire

// file: bench/crypto_run_ctrl_tb.sv
// Self-checking bench of the crypto run controller
`timescale 1ns/100ps
`default_nettype none
`include "crypto_run_params.svh"
module crypto_run_ctrl_tb
  import crypto_run_pkg::*;
();
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic slow = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, mreq, mwe, mgnt, mrv;
  logic civ, cfirst, cir, cov, cor, irq;
  logic [1:0] bresp, rresp, cmode;
  logic [31:0] rdata, maddr, mwdata, mrdata, cvl;
  logic [127:0] cid, cod;
  logic [31:0] vq [$];
  logic [2:0] fq [$];
  int fails = 0, compares = 0, cyc = 0;
  always #5 clk = ~clk;
  crypto_run_ctrl uut (.CLK_SYS(clk), .RST(rst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .MEM_REQ(mreq), .MEM_WE(mwe), .MEM_ADDR(maddr), .MEM_WDATA(mwdata), .MEM_GNT(mgnt),
    .MEM_RVALID(mrv), .MEM_RDATA(mrdata), .CORE_IN_VALID(civ), .CORE_IN_DATA(cid),
    .CORE_FIRST(cfirst), .CORE_MODE(cmode), .CORE_VECTOR_LOW(cvl), .CORE_IN_READY(cir),
    .CORE_OUT_VALID(cov), .CORE_OUT_DATA(cod), .CORE_OUT_READY(cor), .IRQ(irq));
  mem_model pm (.clk(clk), .rst(rst), .slow(slow), .req(mreq), .we(mwe), .addr(maddr),
    .wdata(mwdata), .gnt(mgnt), .rvalid(mrv), .rdata(mrdata));
  core_model #(.W(4)) pc (.clk(clk), .rst(rst), .in_valid(civ), .in_data(cid),
    .out_ready(cor), .in_ready(cir), .out_valid(cov), .out_data(cod));
  // Vector word, first flag and mode seen by the core at every accepted block
  always @(posedge clk) begin
    if (civ && cir) begin
      vq.push_back(cvl);
      fq.push_back({cfirst, cmode});
    end
  end
////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    r = bresp;
    bready <= 1'b0;
    if (n >= 50) fails++;
  endtask
  task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 50) fails++;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    chk(r, 32'h0);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    chk(d, exp);
  endtask
  // Program one fragment, start it and poll until it ends or waits
  task automatic run(input logic [31:0] cfg, s, l, d, fin);
    logic [31:0] st;
    logic [1:0] r;
    int n;
    wr(`CR_ADDR_CONFIG, cfg);
    wr(`CR_ADDR_SRC, s);
    wr(`CR_ADDR_LEN, l);
    wr(`CR_ADDR_DST, d);
    wr(`CR_ADDR_START, 32'h1);
    axi_read(`CR_ADDR_STATUS, st, r);
    chk(st, 32'h0);
    n = 0;
    while (st[1:0] == 2'b00 && n < 200) begin
      axi_read(`CR_ADDR_STATUS, st, r);
      n++;
    end
    chk(st, fin);
  endtask
////////////////////////////////////////
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    rdc(`CR_ADDR_STATUS, 32'h1);
    rdc(`CR_ADDR_START, 32'h0);
    rdc(`CR_ADDR_SRC, 32'h0);
    rdc(`CR_ADDR_LEN, 32'h0);
    rdc(`CR_ADDR_DST, 32'h0);
    rdc(`CR_ADDR_CLRIRQ, 32'h0);
    rdc(`CR_ADDR_MVW0, 32'h0);
    rdc(`CR_ADDR_IRQ_MASK, 32'h3);
    axi_read(32'h40020040, d, r);
    chk(r, 32'h2);
  endtask
  task automatic t_regs;
    logic [1:0] r;
    wr(`CR_ADDR_LEN, 32'hffffffff);
    rdc(`CR_ADDR_LEN, 32'h00ffffff);
    wr(`CR_ADDR_SRC, 32'ha5a5a5a4);
    rdc(`CR_ADDR_SRC, 32'ha5a5a5a4);
    wr(`CR_ADDR_DST, 32'h5a5a5a58);
    rdc(`CR_ADDR_DST, 32'h5a5a5a58);
    wr(`CR_ADDR_MVW0, 32'h12345678);
    rdc(`CR_ADDR_MVW0, 32'h12345678);
    wr(`CR_ADDR_CONFIG, 32'hffffffff);
    rdc(`CR_ADDR_CONFIG, 32'h0001010c);
    axi_write(`CR_ADDR_STATUS, 32'hffffffff, r);
    rdc(`CR_ADDR_STATUS, 32'h1);
    axi_write(32'h40020040, 32'h1, r);
    chk(r, 32'h2);
  endtask
  // Six bytes in ECB on a slow memory: tail zero padded, interrupt raised
  task automatic t_pad;
    @(posedge clk);
    slow <= 1'b1;
    vq.delete();
    fq.delete();
    run(32'h100, 32'h0, 32'h6, 32'h80, 32'h5);
    chk(irq, 32'h1);
    rdc(`CR_ADDR_IRQ_STAT, 32'h1);
    rdc(`CR_ADDR_SRC, 32'h8);
    rdc(`CR_ADDR_LEN, 32'h0);
    rdc(`CR_ADDR_DST, 32'h90);
    chk(pm.mem[32], 32'hbbccddee);
    chk(pm.mem[33], 32'hffff99aa);
    chk(pm.mem[34], 32'hffffffff);
    chk(pm.mem[35], 32'hffffffff);
    chk(vq.size(), 32'h1);
    chk(vq[0], 32'h0);
    chk(fq[0], 32'h4);
    wr(`CR_ADDR_IRQ_MASK, 32'h0);
    @(posedge clk);
    chk(irq, 32'h0);
    wr(`CR_ADDR_IRQ_MASK, 32'h3);
    @(posedge clk);
    chk(irq, 32'h1);
    wr(`CR_ADDR_CLRIRQ, 32'h1);
    rdc(`CR_ADDR_STATUS, 32'h1);
    chk(irq, 32'h0);
    rdc(`CR_ADDR_IRQ_STAT, 32'h0);
  endtask
  // Two CTR fragments; the counter seed sits at the wrap boundary
  task automatic t_frag;
    @(posedge clk);
    slow <= 1'b0;
    wr(`CR_ADDR_MVW0, 32'hffffffff);
    vq.delete();
    fq.delete();
    run(32'h10108, 32'h40, 32'h10, 32'hc0, 32'h6);
    chk(irq, 32'h1);
    rdc(`CR_ADDR_IRQ_STAT, 32'h2);
    wr(`CR_ADDR_IRQ_STAT, 32'h2);
    chk(irq, 32'h0);
    run(32'h8, 32'h50, 32'h10, 32'hd0, 32'h1);
    chk(irq, 32'h0);
    chk(vq.size(), 32'h2);
    chk(vq[0], 32'hffffffff);
    chk(vq[1], 32'h0);
    chk(fq[0], 32'h6);
    chk(fq[1], 32'h2);
    for (int i = 0; i < 8; i++) chk(pm.mem[48 + i], ~(32'h0a0b0c10 + i));
  endtask
  task automatic t_cbc;
    wr(`CR_ADDR_MVW0, 32'h12345678);
    vq.delete();
    fq.delete();
    run(32'hc, 32'h40, 32'h4, 32'he0, 32'h1);
    chk(vq[0], 32'h12345678);
    chk(fq[0], 32'h7);
  endtask
////////////////////////////////////////
  task report_and_stop;
    if (fails == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Whole run needs a few hundred cycles; the ceiling leaves ample margin
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      report_and_stop;
    end
  end
  initial begin
    pm.mem[0] = 32'h44332211;
    pm.mem[1] = 32'h88776655;
    for (int i = 16; i < 24; i++) pm.mem[i] = 32'h0a0b0c00 + i;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_regs;
    t_pad;
    t_frag;
    t_cbc;
    report_and_stop;
  end
endmodule
`default_nettype wire
